// >>> dv/clock_output_gating_and_strap_select_tb.sv
// self-checking bench for the clock output gating block
`timescale 1ns/1ps
module clock_output_gating_and_strap_select_tb;
	import cog_pkg::*;
	logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, pg = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0, spread_amount, pll_c_freq_sel, clk66_outs;
	logic        hreadyout, hresp, bank_a_n = 1'b0, bank_b_n = 1'b0, fs0 = 1'b1, fs1 = 1'b0, test_s = 1'b0;
	logic        sel_pull = 1'b1, c26_pull = 1'b1, sel_pin, c26_pin, sel_out, sel_oe, c26_out, c26_oe;
	logic        ref_src, clk66_src, gig_src, clk26_src, pll_a, pll_b, pll_c, spread_on;
	logic        ref_out, ref_oe, clk66_oe, logic_clk_out, logic_clk_oe, gig_out, gig_oe;
	logic [3:0]  diff_t, diff_c;
	logic        diff_oe, stor_t, stor_c, stor_oe;
	logic [16:0] mon, prv;
	int          cnt[17] = '{default: 0};
	int          base[17];
	int          n_errors = 0;
	int          n_compared = 0;

	always #5 clk = ~clk;

	cog_board board (.sel_out(sel_out), .sel_oe(sel_oe), .c26_out(c26_out), .c26_oe(c26_oe),
		.sel_pull(sel_pull), .c26_pull(c26_pull), .sel_pin(sel_pin), .c26_pin(c26_pin),
		.ref_src(ref_src), .clk66_src(clk66_src), .gig_src(gig_src), .clk26_src(clk26_src),
		.pll_a_clk(pll_a), .pll_b_clk(pll_b), .pll_c_clk(pll_c));

	cog_top uut (.clk(clk), .nrst(nrst), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .ref_src(ref_src), .clk66_src(clk66_src), .gig_src(gig_src),
		.clk26_src(clk26_src), .pll_a_clk(pll_a), .pll_b_clk(pll_b), .pll_c_clk(pll_c),
		.power_good_powerdown_n(pg), .bank_a_enable_n(bank_a_n), .bank_b_enable_n(bank_b_n),
		.freq_strap_0(fs0), .freq_strap_1(fs1), .test_tristate_strap(test_s), .ref_out(ref_out),
		.ref_oe(ref_oe), .clk66_outs(clk66_outs), .clk66_oe(clk66_oe), .logic_clk_out(logic_clk_out),
		.logic_clk_oe(logic_clk_oe), .gig_eth_clk_out(gig_out), .gig_eth_clk_oe(gig_oe),
		.selectable_clk_in(sel_pin), .selectable_clk_out(sel_out), .selectable_clk_oe(sel_oe),
		.clk26_in(c26_pin), .clk26_out(c26_out), .clk26_oe(c26_oe), .diff_ref_pairs_t(diff_t),
		.diff_ref_pairs_c(diff_c), .diff_ref_oe(diff_oe), .storage_ref_pair_t(stor_t),
		.storage_ref_pair_c(stor_c), .storage_ref_oe(stor_oe), .spread_on(spread_on),
		.spread_amount(spread_amount), .pll_c_freq_sel(pll_c_freq_sel));

	////////////////////////////////////////////////////////////////////////////////
	// rising edge counters on every clock leg, as seen at the pin
	assign mon = {stor_c & stor_oe, diff_c & {4{diff_oe}}, stor_t & stor_oe, diff_t & {4{diff_oe}},
		c26_out & c26_oe, sel_out & sel_oe, gig_out & gig_oe, logic_clk_out & logic_clk_oe,
		clk66_outs & {2{clk66_oe}}, ref_out & ref_oe};
	always @(posedge clk) begin
		prv <= mon;
		for (int i = 0; i < 17; i++) if (mon[i] && !prv[i]) cnt[i] <= cnt[i] + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, bus and measurement tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_near(input int got, input int exp);
		n_compared++;
		if (got < exp - 1 || got > exp + 1) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_rdy();
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic run_chk(input logic [16:0] exp);
		logic [16:0] ran;
		repeat (40) @(posedge clk);
		base = cnt;
		repeat (200) @(posedge clk);
		for (int i = 0; i < 17; i++) ran[i] = (cnt[i] != base[i]) || (!exp[i] && mon[i] !== 1'b0);
		chk(32'(ran), 32'(exp));
	endtask

	task automatic complete_run();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		rd(CTRL1_OFS, 32'h80);
		rd(CTRL4_OFS, 32'h0);
		rd(CTRL0_OFS, 32'h0);
		rd(OUT_EN_OFS, 32'hfff);
		wr(32'h20, 32'hffff_ffff);
		rd(32'h20, 32'h0);
		run_chk(17'h0);
		chk(32'({sel_oe, c26_oe}), 32'h0);
		pg <= 1'b1;
		run_chk(17'h1ffff);
		rd(STATUS_OFS, 32'h1f);
		chk(32'({ref_oe, clk66_oe, logic_clk_oe, gig_oe, sel_oe, c26_oe, diff_oe, stor_oe}), 32'hff);
		bank_a_n <= 1'b1;
		run_chk(17'h1ce7f);
		bank_a_n <= 1'b0;
		run_chk(17'h1ffff);
		bank_b_n <= 1'b1;
		run_chk(17'h139ff);
		bank_b_n <= 1'b0;
		run_chk(17'h1ffff);
		wr(OUT_EN_OFS, 32'h797);
		run_chk(17'h0f797);
		chk(32'({sel_oe, c26_oe}), 32'h3);
		wr(OUT_EN_OFS, 32'hfff);
		pg <= 1'b0;
		fs0 <= 1'b0;
		run_chk(17'h0007f);
		chk(32'({sel_oe, c26_oe}), 32'h3);
		wr(CTRL1_OFS, 32'h0);
		run_chk(17'h0);
		chk(32'({sel_oe, c26_oe}), 32'h0);
		rd(STATUS_OFS, 32'h1d);
		wr(CTRL1_OFS, 32'(1) << RUN_PD_BIT);
		pg <= 1'b1;
		run_chk(17'h1ffff);
		rd(STATUS_OFS, 32'h1f);
		for (int k = 0; k < 4; k++) begin
			wr(CTRL0_OFS, 32'(k) << DIV_SEL_LSB);
			rd(CTRL0_OFS, 32'(k) << DIV_SEL_LSB);
			repeat (40) @(posedge clk);
			base = cnt;
			repeat (512) @(posedge clk);
			chk_near(cnt[3] - base[3], 64 >> k);
			chk_near(cnt[5] - base[5], 32);
			chk_near(cnt[7] - base[7], 64);
		end
		for (int s = 0; s < 4; s++) begin
			wr(CTRL4_OFS, (32'(s) << SS_SEL_LSB) | 32'h1);
			repeat (4) @(posedge clk);
			chk(32'(spread_amount), 32'(s));
			chk(32'(spread_on), 32'(s != 3));
		end
		wr(CTRL4_OFS, 32'h2);
		repeat (4) @(posedge clk);
		chk(32'(spread_on), 32'h0);
		nrst <= 1'b0;
		pg <= 1'b0;
		test_s <= 1'b1;
		sel_pull <= 1'b0;
		c26_pull <= 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'({sel_oe, c26_oe}), 32'h0);
		pg <= 1'b1;
		run_chk(17'h0);
		rd(STATUS_OFS, 32'h43);
		chk(32'({ref_oe, clk66_oe, logic_clk_oe, gig_oe, sel_oe, c26_oe, diff_oe, stor_oe}), 32'h0);
		nrst <= 1'b0;
		pg <= 1'b0;
		test_s <= 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		pg <= 1'b1;
		run_chk(17'h1ffff);
		rd(STATUS_OFS, 32'h3);
		chk(32'(pll_c_freq_sel), 32'h0);
		base = cnt;
		repeat (512) @(posedge clk);
		chk_near(cnt[5] - base[5], 37);
		chk_near(cnt[7] - base[7], 43);
		chk_near(cnt[11] - base[11], 43);
		complete_run();
	end
endmodule

// >>> dv/cog_board.sv
// board model: source oscillators and strap resistors on the latched pins
`timescale 1ns/1ps
module cog_board (
	input  wire logic sel_out,
	input  wire logic sel_oe,
	input  wire logic c26_out,
	input  wire logic c26_oe,
	input  wire logic sel_pull,
	input  wire logic c26_pull,
	output logic      sel_pin,
	output logic      c26_pin,
	output logic      ref_src,
	output logic      clk66_src,
	output logic      gig_src,
	output logic      clk26_src,
	output logic      pll_a_clk,
	output logic      pll_b_clk,
	output logic      pll_c_clk
);
	////////////////////////////////////////////////////////////////////////////////
	// strap resistor sets the level while the device floats the pin
	assign sel_pin = sel_oe ? sel_out : sel_pull;
	assign c26_pin = c26_oe ? c26_out : c26_pull;
	////////////////////////////////////////////////////////////////////////////////
	// free running sources, well below the 100 MHz sampling clock
	initial begin
		{ref_src, clk66_src, gig_src, clk26_src, pll_a_clk, pll_b_clk, pll_c_clk} = 7'h0;
	end
	always #50 ref_src = ~ref_src;
	always #30 clk66_src = ~clk66_src;
	always #30 gig_src = ~gig_src;
	always #40 clk26_src = ~clk26_src;
	always #40 pll_a_clk = ~pll_a_clk;
	always #60 pll_b_clk = ~pll_b_clk;
	always #70 pll_c_clk = ~pll_c_clk;
endmodule

// >>> hw/cog_gate.sv
// glitch-free gate for one output clock
`timescale 1ns/1ps
module cog_gate
	import cog_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic src_lvl,
	input  wire logic run_req,
	output logic      run_q,
	output logic      clk_q,
	output logic      comp_q
);

	logic open_ff;
	logic out_ff;
	logic comp_ff;
	logic nxt_open;
	logic nxt_out;
	logic nxt_comp;

	////////////////////////////////////////////////////////////////////////////
	// open or close only while the source is low
	always_comb begin
		nxt_open = src_lvl ? open_ff : run_req; // see R20
		nxt_out  = nxt_open & src_lvl;
		nxt_comp = nxt_open & ~src_lvl;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_ff <= 1'b0;
			out_ff  <= 1'b0;
			comp_ff <= 1'b0;
		end else if (clk_en) begin
			open_ff <= nxt_open;
			out_ff  <= nxt_out;
			comp_ff <= nxt_comp;
		end
	end

	assign run_q  = open_ff;
	assign clk_q  = out_ff;
	assign comp_q = comp_ff;

	////////////////////////////////////////////////////////////////////////////
	gate_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R20
		(clk_en && src_lvl) |=> (open_ff == $past(open_ff)))
		else $error("gate changed while source high");

	gate_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // see R20
		(clk_en && !src_lvl && !run_req) |=> (!open_ff && !out_ff && !comp_ff))
		else $error("gate did not close at source low");

endmodule

// >>> hw/cog_pkg.sv
// constants shared by the clock output gating block
package cog_pkg;

	localparam logic [31:0] CTRL0_OFS     = 32'h0000_0000;
	localparam logic [31:0] CTRL1_OFS     = 32'h0000_0004;
	localparam logic [31:0] OUT_EN_OFS    = 32'h0000_0008;
	localparam logic [31:0] STATUS_OFS    = 32'h0000_000c;
	localparam logic [31:0] CTRL4_OFS     = 32'h0000_0010;
	localparam int          ADDR_W        = 8;

	localparam int          DIV_SEL_LSB   = 2;
	localparam int          RUN_PD_BIT    = 7;
	localparam int          SS_EN_BIT     = 0;
	localparam int          SS_SEL_LSB    = 1;

	localparam logic [1:0]  DIV_SEL_RST   = 2'h0;
	localparam logic        RUN_PD_RST    = 1'h1;
	localparam logic        SS_EN_RST     = 1'h0;
	localparam logic [1:0]  SS_SEL_RST    = 2'h0;
	localparam logic [1:0]  SS_SEL_NONE   = 2'h3;

	localparam int          NGATE         = 12;
	localparam logic [11:0] OUT_EN_RST    = 12'hfff;
	localparam int          G_REF         = 0;
	localparam int          G_66_0        = 1;
	localparam int          G_66_1        = 2;
	localparam int          G_LOGIC       = 3;
	localparam int          G_GIG         = 4;
	localparam int          G_SEL         = 5;
	localparam int          G_26          = 6;
	localparam int          G_DIFF0       = 7;
	localparam int          G_STOR        = 11;

	localparam int          NSYNC         = 15;
	localparam int          S_REF         = 0;
	localparam int          S_66          = 1;
	localparam int          S_GIG         = 2;
	localparam int          S_26          = 3;
	localparam int          S_PLLA        = 4;
	localparam int          S_PLLB        = 5;
	localparam int          S_PLLC        = 6;
	localparam int          S_PG          = 7;
	localparam int          S_BANKA       = 8;
	localparam int          S_BANKB       = 9;
	localparam int          S_STRAP_SRC   = 10;
	localparam int          S_STRAP_SEL   = 11;
	localparam int          S_FS0         = 12;
	localparam int          S_FS1         = 13;
	localparam int          S_TEST        = 14;

	localparam int          ST_STARTED    = 0;
	localparam int          ST_PG         = 1;
	localparam int          ST_STRAP_LSB  = 2;
	localparam int          ST_SPREAD     = 7;

	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

endpackage

// >>> hw/cog_top.sv
// clock output gating, strap latch and config registers
// Functional notes
// R01: ref, 66, logic, gig outputs run if enabled and power-good or run-in-powerdown.
// R02: diff pairs run only with power-good, enable set and bank enable low.
// R03: bank A enable low runs pairs 0 and 1; high stops them.
// R04: bank B enable low runs pairs 2 and 3; high stops them.
// R05: storage pair runs only with power-good and its enable; both legs low else.
// R06: selectable and 26 MHz pins float in powerdown without run bit; else low/run.
// R07: selectable and 26 MHz pins float until first power-good high.
// R08: first power-good rise samples straps, holds them, starts outputs.
// R09: later power-good low is powerdown, high resumes; straps never re-sampled.
// R10: spread off unless enabled; select 00/01/10/11 gives -0.5/-0.4/-0.3/none.
// R11: spread select resets to 00.
// R12: spread reaches diff pairs only when source strap latched 1.
// R13: source strap 0 picks non-spread PLL, 1 spread PLL for diff pairs.
// R14: selectable clock from aux PLL or divided spread PLL per straps.
// R15: logic clock divides spread PLL by 1, 2, 4 or 8 per control field.
// R16: test strap latched 1 floats every clock output.
// R17: run-in-powerdown bit is control 1 bit 7, resets to 1.
// R18: bank enable high stops its pairs within a few output periods.
// R19: bank enable low restarts its pairs within a few output periods.
// R20: every gate opens and closes only while its source is low.
`timescale 1ns/1ps
module cog_top
	import cog_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        ref_src,
	input  wire logic        clk66_src,
	input  wire logic        gig_src,
	input  wire logic        clk26_src,
	input  wire logic        pll_a_clk,
	input  wire logic        pll_b_clk,
	input  wire logic        pll_c_clk,
	input  wire logic        power_good_powerdown_n,
	input  wire logic        bank_a_enable_n,
	input  wire logic        bank_b_enable_n,
	input  wire logic        freq_strap_0,
	input  wire logic        freq_strap_1,
	input  wire logic        test_tristate_strap,
	output logic             ref_out,
	output logic             ref_oe,
	output logic [1:0]       clk66_outs,
	output logic             clk66_oe,
	output logic             logic_clk_out,
	output logic             logic_clk_oe,
	output logic             gig_eth_clk_out,
	output logic             gig_eth_clk_oe,
	input  wire logic        selectable_clk_in,
	output logic             selectable_clk_out,
	output logic             selectable_clk_oe,
	input  wire logic        clk26_in,
	output logic             clk26_out,
	output logic             clk26_oe,
	output logic [3:0]       diff_ref_pairs_t,
	output logic [3:0]       diff_ref_pairs_c,
	output logic             diff_ref_oe,
	output logic             storage_ref_pair_t,
	output logic             storage_ref_pair_c,
	output logic             storage_ref_oe,
	output logic             spread_on,
	output logic [1:0]       spread_amount,
	output logic [1:0]       pll_c_freq_sel
);

	function automatic logic div_level(input logic [2:0] cnt, input logic lvl, input logic [1:0] sel);
		logic r;
		r = lvl;
		unique case (sel)
			2'h0: r = lvl;
			2'h1: r = cnt[0];
			2'h2: r = cnt[1];
			2'h3: r = cnt[2];
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	logic             rst_a_ff;
	logic             rst_n;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	logic [NSYNC-1:0] pins;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_a_ff <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_n    <= rst_a_ff;
		end
	end

	assign pins = {test_tristate_strap, freq_strap_1, freq_strap_0, selectable_clk_in, clk26_in,
		bank_b_enable_n, bank_a_enable_n, power_good_powerdown_n,
		pll_c_clk, pll_b_clk, pll_a_clk, clk26_src, gig_src, clk66_src, ref_src};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else if (clk_en) begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// start-up and strap latch
	logic       pg_d_ff;
	logic       started_ff;
	logic [4:0] strap_ff;
	logic       nxt_pg_d;
	logic       nxt_started;
	logic [4:0] nxt_strap;
	logic       pg;
	logic       src_strap;
	logic       sel_strap;
	logic [1:0] fs_strap;
	logic       test_lat;

	assign pg = sync2_ff[S_PG];

	always_comb begin
		nxt_pg_d    = pg;
		nxt_started = started_ff;
		nxt_strap   = strap_ff;
		if (pg && !pg_d_ff && !started_ff) begin
			nxt_started = 1'b1; // see R08
			nxt_strap   = sync2_ff[S_TEST:S_STRAP_SRC]; // see R08, R09
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pg_d_ff    <= 1'b0;
			started_ff <= 1'b0;
			strap_ff   <= '0;
		end else if (clk_en) begin
			pg_d_ff    <= nxt_pg_d;
			started_ff <= nxt_started;
			strap_ff   <= nxt_strap;
		end
	end

	assign src_strap = strap_ff[0];
	assign sel_strap = strap_ff[1];
	assign fs_strap  = strap_ff[3:2];
	assign test_lat  = strap_ff[4];

	////////////////////////////////////////////////////////////////////////////
	// register file over the bus
	logic [1:0]        div_sel_ff;
	logic              run_pd_ff;
	logic              ss_en_ff;
	logic [1:0]        ss_sel_ff;
	logic [NGATE-1:0]  out_en_ff;
	logic              wr_pend_ff;
	logic [ADDR_W-1:0] wr_addr_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        nxt_div_sel;
	logic              nxt_run_pd;
	logic              nxt_ss_en;
	logic [1:0]        nxt_ss_sel;
	logic [NGATE-1:0]  nxt_out_en;
	logic              nxt_wr_pend;
	logic [ADDR_W-1:0] nxt_wr_addr;
	logic [31:0]       nxt_rdata;
	logic              take;
	logic [31:0]       status;

	assign take   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
	assign status = {24'h0, spread_on, strap_ff, pg, started_ff};

	always_comb begin
		nxt_div_sel = div_sel_ff;
		nxt_run_pd  = run_pd_ff;
		nxt_ss_en   = ss_en_ff;
		nxt_ss_sel  = ss_sel_ff;
		nxt_out_en  = out_en_ff;
		nxt_wr_pend = take && hwrite;
		nxt_wr_addr = haddr[ADDR_W-1:0];
		nxt_rdata   = rdata_ff;
		if (wr_pend_ff) begin
			unique case ({24'h0, wr_addr_ff})
				CTRL0_OFS:  nxt_div_sel = hwdata[DIV_SEL_LSB+:2]; // see R15
				CTRL1_OFS:  nxt_run_pd  = hwdata[RUN_PD_BIT]; // see R17
				OUT_EN_OFS: nxt_out_en  = hwdata[NGATE-1:0];
				CTRL4_OFS: begin
					nxt_ss_en  = hwdata[SS_EN_BIT]; // see R10
					nxt_ss_sel = hwdata[SS_SEL_LSB+:2]; // see R10
				end
				default: ;
			endcase
		end
		if (take && !hwrite) begin
			unique case ({24'h0, haddr[ADDR_W-1:0]} & ~32'h3)
				CTRL0_OFS:  nxt_rdata = {28'h0, nxt_div_sel, 2'h0};
				CTRL1_OFS:  nxt_rdata = {24'h0, nxt_run_pd, 7'h0};
				OUT_EN_OFS: nxt_rdata = {20'h0, nxt_out_en};
				STATUS_OFS: nxt_rdata = status;
				CTRL4_OFS:  nxt_rdata = {29'h0, nxt_ss_sel, nxt_ss_en};
				default:    nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_sel_ff <= DIV_SEL_RST;
			run_pd_ff  <= RUN_PD_RST; // see R17
			ss_en_ff   <= SS_EN_RST;
			ss_sel_ff  <= SS_SEL_RST; // see R11
			out_en_ff  <= OUT_EN_RST;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			rdata_ff   <= 32'h0;
		end else if (clk_en) begin
			div_sel_ff <= nxt_div_sel;
			run_pd_ff  <= nxt_run_pd;
			ss_en_ff   <= nxt_ss_en;
			ss_sel_ff  <= nxt_ss_sel;
			out_en_ff  <= nxt_out_en;
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			rdata_ff   <= nxt_rdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// spread PLL divider and source selection
	logic [2:0]       cnt_ff;
	logic             plla_d_ff;
	logic [2:0]       nxt_cnt;
	logic [NGATE-1:0] src;
	logic [NGATE-1:0] req;
	logic [NGATE-1:0] gclk;
	logic [NGATE-1:0] gcomp;
	logic [NGATE-1:0] grun;
	logic             diff_src;
	logic             se_ok;
	logic             diff_ok;
	logic [3:0]       bank_ok;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (sync2_ff[S_PLLA] && !plla_d_ff)
			nxt_cnt = cnt_ff + 3'h1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff    <= 3'h0;
			plla_d_ff <= 1'b0;
		end else if (clk_en) begin
			cnt_ff    <= nxt_cnt;
			plla_d_ff <= sync2_ff[S_PLLA];
		end
	end

	assign spread_on      = ss_en_ff && (ss_sel_ff != SS_SEL_NONE); // see R10
	assign spread_amount  = ss_sel_ff;
	assign pll_c_freq_sel = fs_strap; // see R14
	assign diff_src       = src_strap ? sync2_ff[S_PLLA] : sync2_ff[S_PLLB]; // see R12, R13

	always_comb begin
		src          = '0;
		src[G_REF]   = sync2_ff[S_REF];
		src[G_66_0]  = sync2_ff[S_66];
		src[G_66_1]  = sync2_ff[S_66];
		src[G_LOGIC] = div_level(cnt_ff, sync2_ff[S_PLLA], div_sel_ff); // see R15
		src[G_GIG]   = sync2_ff[S_GIG];
		src[G_SEL]   = sel_strap ? div_level(cnt_ff, sync2_ff[S_PLLA], fs_strap) : sync2_ff[S_PLLC]; // see R14
		src[G_26]    = sync2_ff[S_26];
		src[G_DIFF0+:4] = {4{diff_src}};
		src[G_STOR]  = sync2_ff[S_PLLB];
	end

	////////////////////////////////////////////////////////////////////////////
	// run requests per output
	assign se_ok   = started_ff && (pg || run_pd_ff); // see R01, R06, R09
	assign diff_ok = started_ff && pg; // see R02, R05
	assign bank_ok = {{2{!sync2_ff[S_BANKB]}}, {2{!sync2_ff[S_BANKA]}}}; // see R03, R04, R18, R19

	always_comb begin
		req             = out_en_ff & {NGATE{se_ok}}; // see R01, R06
		req[G_DIFF0+:4] = out_en_ff[G_DIFF0+:4] & bank_ok & {4{diff_ok}}; // see R02
		req[G_STOR]     = out_en_ff[G_STOR] & diff_ok; // see R05
	end

	for (genvar g = 0; g < NGATE; g++) begin : gates
		cog_gate u_gate (
			.clk     (clk),
			.rst_n   (rst_n),
			.clk_en  (clk_en),
			.src_lvl (src[g]),
			.run_req (req[g]),
			.run_q   (grun[g]),
			.clk_q   (gclk[g]),
			.comp_q  (gcomp[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// pins
	assign ref_out            = gclk[G_REF];
	assign clk66_outs         = gclk[G_66_1:G_66_0];
	assign logic_clk_out      = gclk[G_LOGIC];
	assign gig_eth_clk_out    = gclk[G_GIG];
	assign selectable_clk_out = gclk[G_SEL];
	assign clk26_out          = gclk[G_26];
	assign diff_ref_pairs_t   = gclk[G_DIFF0+:4];
	assign diff_ref_pairs_c   = gcomp[G_DIFF0+:4];
	assign storage_ref_pair_t = gclk[G_STOR];
	assign storage_ref_pair_c = gcomp[G_STOR];
	assign ref_oe             = !test_lat; // see R16
	assign clk66_oe           = !test_lat;
	assign logic_clk_oe       = !test_lat;
	assign gig_eth_clk_oe     = !test_lat;
	assign diff_ref_oe        = !test_lat;
	assign storage_ref_oe     = !test_lat;
	assign selectable_clk_oe  = !test_lat && started_ff && (pg || run_pd_ff); // see R06, R07
	assign clk26_oe           = !test_lat && started_ff && (pg || run_pd_ff); // see R06, R07

	////////////////////////////////////////////////////////////////////////////
	sequence first_rise_s;
		pg && !pg_d_ff && !started_ff && clk_en;
	endsequence

	sequence latched_s;
		##1 started_ff && (strap_ff == $past(sync2_ff[S_TEST:S_STRAP_SRC]));
	endsequence

	strap_capture_a: assert property (@(posedge clk) disable iff (!rst_n) // see R08
		first_rise_s |-> latched_s)
		else $error("straps not captured on first power-good rise");

	strap_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R09
		(started_ff && $past(started_ff)) |-> $stable(strap_ff))
		else $error("straps changed after start");

	prestart_float_a: assert property (@(posedge clk) disable iff (!rst_n) // see R07
		!started_ff |-> (!selectable_clk_oe && !clk26_oe && !gclk[G_SEL] && !gclk[G_26]))
		else $error("latched pins driven before start");

	test_float_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
		test_lat |-> !(ref_oe || clk66_oe || logic_clk_oe || gig_eth_clk_oe || diff_ref_oe
			|| storage_ref_oe || selectable_clk_oe || clk26_oe))
		else $error("output driven in test mode");

	pd_float_a: assert property (@(posedge clk) disable iff (!rst_n) // see R06
		(!pg && !run_pd_ff) |-> (!selectable_clk_oe && !clk26_oe))
		else $error("latched pins driven in powerdown");

	bank_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // see R03
		(sync2_ff[S_BANKA] && !sync2_ff[S_PLLA] && !sync2_ff[S_PLLB] && clk_en)
			|=> (diff_ref_pairs_t[1:0] == 2'h0 && diff_ref_pairs_c[1:0] == 2'h0))
		else $error("bank A pair still running");

	diff_pd_a: assert property (@(posedge clk) disable iff (!rst_n) // see R02, R05
		(!pg && !diff_src && !sync2_ff[S_PLLB] && clk_en)
			|=> (diff_ref_pairs_t == 4'h0 && diff_ref_pairs_c == 4'h0 && !storage_ref_pair_c && !storage_ref_pair_t))
		else $error("differential pair running in powerdown");

	src_route_a: assert property (@(posedge clk) disable iff (!rst_n) // see R13
		(started_ff && !src_strap) |-> (diff_src == sync2_ff[S_PLLB]))
		else $error("diff pairs not on non-spread PLL");

	spread_reset_a: assert property (@(posedge clk) // see R11, R17
		$rose(rst_n) |-> (ss_sel_ff == 2'h0 && run_pd_ff && !spread_on))
		else $error("spread or run bit reset value wrong");

	spread_off_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
		(!ss_en_ff || ss_sel_ff == 2'h3) |-> !spread_on)
		else $error("spread active while disabled");

endmodule
